// ===== ddc_pkg.sv
package ddc_pkg;
  localparam int NCH = 4;
  localparam int SW = 14;
  localparam int PW = 12;
  localparam int CW = 16;
  localparam int AW = 12;
  localparam int IW = 10;

  typedef logic signed [SW-1:0] smp_t;
  typedef logic signed [CW-1:0] coef_t;
  typedef logic signed [47:0] wide_t;

  typedef struct packed {
    logic valid;
    smp_t i;
    smp_t q;
  } stream_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    IF_VARIABLE = 2'b00,
    IF_ZERO = 2'b01,
    IF_QUARTER = 2'b10,
    IF_TEST = 2'b11
  } if_mode_t;

  typedef struct packed {
    logic hit;
    logic isCh;
    logic [1:0] ch;
    logic [1:0] sub;
    logic [IW-1:0] idx;
  } regsel_t;

  // Register indices; byte address is four times the index
  localparam logic [IW-1:0] IDX_SYSREF_CTRL = 10'h120;
  localparam logic [IW-1:0] IDX_SYSREF_CTRL2 = 10'h121;
  localparam logic [IW-1:0] IDX_SYNC_CTRL = 10'h300;
  localparam logic [IW-1:0] IDX_SYNC_STAT = 10'h301;
  localparam logic [IW-1:0] IDX_CH_CTRL0 = 10'h310;
  localparam logic [IW-1:0] CH_STRIDE = 10'h020;
  localparam logic [1:0] SUB_CTRL = 2'h0;
  localparam logic [1:0] SUB_STEP = 2'h1;
  localparam logic [1:0] SUB_START = 2'h2;
  localparam logic [1:0] SUB_PHASE = 2'h3;

  // Field positions and reset values
  localparam int CTRL_COMPLEX_BIT = 7;
  localparam int CTRL_MODE_LSB = 4;
  localparam int SYNC_SOFT_BIT = 4;
  localparam int SYNC_EN_LSB = 0;
  localparam int SYSREF_EN_BIT = 0;
  localparam int STAT_SOFT_BIT = 8;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [PW-1:0] WORD12_RST = 12'h000;

  // Oscillator and mixer constants
  localparam logic [PW-1:0] QUARTER_STEP = 12'h400;
  localparam int PH_TOP_LSB = 6;
  localparam logic [5:0] QUARTER_TURN = 6'h10;
  localparam logic [4:0] QTR_ENTRIES = 5'h10;
  localparam smp_t TEST_LEVEL = 14'sh1FF7;
  localparam smp_t SMP_MAX = 14'sh1FFF;
  localparam smp_t SMP_MIN = -14'sh2000;
  localparam coef_t COMPLEX_SCALE = 16'sh59FF;
  localparam logic [5:0] SHIFT_REAL = 6'h0F;
  localparam logic [5:0] SHIFT_CPLX = 6'h1E;
  localparam logic [CW-1:0] SINE_TAB [17] = '{
    16'h0000, 16'h0C79, 16'h18D4, 16'h24F1, 16'h30B3, 16'h3BFD,
    16'h46B4, 16'h50BC, 16'h59FD, 16'h6260, 16'h69D0, 16'h703C,
    16'h7593, 16'h79C8, 16'h7CD1, 16'h7EA6, 16'h7F43};
endpackage : ddc_pkg

// ===== ddc_nco_mixer_translation.sv
`timescale 1ns/100ps

// Contract
// - Each channel shifts real or complex input to complex baseband via 12-bit NCO.
// - Bits 5:4 of each channel control register select the IF mode.
// - Variable IF runs oscillator and mixer; step word sets tuned frequency.
// - Zero IF bypasses the mixer and holds the oscillator still.
// - Quarter-rate IF downmixes by fs/4 with a multiplier-free path.
// - Test mode feeds 0.999 full scale into the running oscillator mixer.
// - Real mixing shows 6 dB image loss plus 0.05 dB oscillator loss.
// - Complex mixing scales output down 3.06 dB to avoid overrange.
// - Step word is 12-bit twos complement, 0x800 is minus half rate.
// - Each oscillator takes a 12-bit phase start word.
// - Accumulator loads start word on sync, adds step word each sample.
// - Soft reset bit high then low resets all accumulators.
// - Enabled SYSREF events reset all accumulators.
// - Real input uses two multipliers; complex uses four and two adders.
// - Bit 7 of each channel control register selects complex input.
module ddc_nco_mixer_translation (
  input logic sys_clk,
  input logic srst,
  input ddc_pkg::apb_req_t apbReq,
  output ddc_pkg::apb_rsp_t apbRsp,
  input logic sysrefPin,
  input ddc_pkg::stream_t adcIn,
  output ddc_pkg::stream_t [ddc_pkg::NCH-1:0] mixOut
);
  import ddc_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic regsel_t decodeAddr(logic [AW-1:0] a);
    regsel_t s;
    logic [IW-1:0] base;
    s = '0;
    s.idx = a[AW-1:2];
    if (a[1:0] == 2'b00) begin
      if (s.idx == IDX_SYSREF_CTRL || s.idx == IDX_SYSREF_CTRL2 ||
          s.idx == IDX_SYNC_CTRL || s.idx == IDX_SYNC_STAT) begin
        s.hit = 1'b1;
      end
      for (int c = 0; c < NCH; c++) begin
        base = IDX_CH_CTRL0 + CH_STRIDE * IW'(c);
        for (int k = 0; k < 4; k++) begin
          if (s.idx == base + IW'(k)) begin
            s.hit = 1'b1;
            s.isCh = 1'b1;
            s.ch = 2'(c);
            s.sub = 2'(k);
          end
        end
      end
    end
    return s;
  endfunction : decodeAddr

  function automatic coef_t oscSine(logic [5:0] p);
    logic [4:0] j;
    coef_t m;
    j = p[4] ? QTR_ENTRIES - {1'b0, p[3:0]} : {1'b0, p[3:0]};
    m = coef_t'(SINE_TAB[j]);
    return p[5] ? -m : m;
  endfunction : oscSine

  function automatic smp_t roundSat(wide_t v, logic [5:0] sh);
    wide_t r;
    r = (v + (48'sd1 <<< (sh - 6'd1))) >>> sh;
    if (r > 48'(SMP_MAX)) begin
      return SMP_MAX;
    end
    if (r < 48'(SMP_MIN)) begin
      return SMP_MIN;
    end
    return r[SW-1:0];
  endfunction : roundSat

  function automatic smp_t negSat(smp_t x);
    return (x == SMP_MIN) ? SMP_MAX : -x;
  endfunction : negSat

  function automatic wide_t mul(smp_t x, coef_t c);
    return 48'(x) * 48'(c);
  endfunction : mul

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0] chCtrl [NCH];
  logic [PW-1:0] frequency_step_word [NCH];
  logic [PW-1:0] phase_start_word [NCH];
  logic [PW-1:0] phase_accumulator [NCH];
  logic [7:0] sysrefCtrl;
  logic [7:0] sysrefCtrl2;
  logic [7:0] syncCtrl;
  logic [7:0] sysrefSyncCount;
  logic sysrefMeta;
  logic sysrefSync;
  logic sysrefLast;
  logic sysrefEvent;
  logic sysrefTaken;
  logic syncNow;
  logic apbSetup;
  logic apbAccess;
  regsel_t sel;
  logic [31:0] readValue;

  // ----------------------------------------
  // SYSREF synchroniser and sync request
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sysrefMeta <= 1'b0;
      sysrefSync <= 1'b0;
      sysrefLast <= 1'b0;
    end else begin
      sysrefMeta <= sysrefPin;
      sysrefSync <= sysrefMeta;
      sysrefLast <= sysrefSync;
    end
  end

  assign sysrefEvent = sysrefSync & ~sysrefLast;
  assign sysrefTaken = sysrefEvent & sysrefCtrl[SYSREF_EN_BIT] &
                       (|syncCtrl[SYNC_EN_LSB +: 2]);
  // Soft reset holds every accumulator at its start word until cleared
  assign syncNow = syncCtrl[SYNC_SOFT_BIT] | sysrefTaken;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sysrefSyncCount <= REG8_RST;
    end else if (sysrefTaken) begin
      sysrefSyncCount <= sysrefSyncCount + 8'h01;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apbSetup = apbReq.psel & ~apbReq.penable;
  assign apbAccess = apbReq.psel & apbReq.penable & apbRsp.pready;
  assign sel = decodeAddr(apbReq.paddr);

  always_comb begin
    readValue = '0;
    if (sel.isCh) begin
      unique case (sel.sub)
        SUB_CTRL: readValue[7:0] = chCtrl[sel.ch];
        SUB_STEP: readValue[PW-1:0] = frequency_step_word[sel.ch];
        SUB_START: readValue[PW-1:0] = phase_start_word[sel.ch];
        SUB_PHASE: readValue[PW-1:0] = phase_accumulator[sel.ch];
      endcase
    end else if (sel.idx == IDX_SYSREF_CTRL) begin
      readValue[7:0] = sysrefCtrl;
    end else if (sel.idx == IDX_SYSREF_CTRL2) begin
      readValue[7:0] = sysrefCtrl2;
    end else if (sel.idx == IDX_SYNC_CTRL) begin
      readValue[7:0] = syncCtrl;
    end else if (sel.idx == IDX_SYNC_STAT) begin
      readValue[7:0] = sysrefSyncCount;
      readValue[STAT_SOFT_BIT] = syncCtrl[SYNC_SOFT_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= apbSetup;
      apbRsp.pslverr <= apbSetup & ~sel.hit;
      apbRsp.prdata <= (apbSetup & sel.hit) ? readValue : '0;
    end
  end

  // Register writes take effect on the completing access edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sysrefCtrl <= REG8_RST;
      sysrefCtrl2 <= REG8_RST;
      syncCtrl <= REG8_RST;
      for (int c = 0; c < NCH; c++) begin
        chCtrl[c] <= REG8_RST;
        frequency_step_word[c] <= WORD12_RST;
        phase_start_word[c] <= WORD12_RST;
      end
    end else if (apbAccess && apbReq.pwrite && sel.hit) begin
      if (sel.isCh) begin
        unique case (sel.sub)
          SUB_CTRL: chCtrl[sel.ch] <= apbReq.pwdata[7:0];
          SUB_STEP: frequency_step_word[sel.ch] <= apbReq.pwdata[PW-1:0];
          SUB_START: phase_start_word[sel.ch] <= apbReq.pwdata[PW-1:0];
          SUB_PHASE: ;
        endcase
      end else if (sel.idx == IDX_SYSREF_CTRL) begin
        sysrefCtrl <= apbReq.pwdata[7:0];
      end else if (sel.idx == IDX_SYSREF_CTRL2) begin
        sysrefCtrl2 <= apbReq.pwdata[7:0];
      end else if (sel.idx == IDX_SYNC_CTRL) begin
        syncCtrl <= apbReq.pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Per-channel oscillator and mixer
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    if_mode_t mode;
    logic cplx;
    logic [PW-1:0] step;
    coef_t oscCos;
    coef_t oscSin;
    smp_t xI;
    smp_t xQ;
    logic v1;
    if_mode_t mode1;
    logic cplx1;
    logic [1:0] quad1;
    wide_t sumI;
    wide_t sumQ;
    smp_t outI;
    smp_t outQ;

    assign mode = if_mode_t'(chCtrl[c][CTRL_MODE_LSB +: 2]);
    assign cplx = chCtrl[c][CTRL_COMPLEX_BIT];
    // Twos complement step wraps modulo one turn of the phase
    assign step = (mode == IF_QUARTER) ? QUARTER_STEP
                                       : frequency_step_word[c];

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        phase_accumulator[c] <= WORD12_RST;
      end else if (syncNow) begin
        phase_accumulator[c] <= phase_start_word[c];
      end else if (adcIn.valid && mode != IF_ZERO) begin
        phase_accumulator[c] <= phase_accumulator[c] + step;
      end
    end

    // Stage one: oscillator lookup and input selection
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        oscCos <= '0;
        oscSin <= '0;
        xI <= '0;
        xQ <= '0;
        v1 <= 1'b0;
        mode1 <= IF_VARIABLE;
        cplx1 <= 1'b0;
        quad1 <= 2'b00;
      end else begin
        // Table peak carries the small oscillator loss
        oscSin <= oscSine(phase_accumulator[c][PW-1:PH_TOP_LSB]);
        oscCos <= oscSine(phase_accumulator[c][PW-1:PH_TOP_LSB] +
                          QUARTER_TURN);
        xI <= (mode == IF_TEST) ? TEST_LEVEL : adcIn.i;
        xQ <= (mode == IF_TEST || !cplx) ? '0 : adcIn.q;
        v1 <= adcIn.valid;
        mode1 <= mode;
        cplx1 <= cplx;
        quad1 <= phase_accumulator[c][PW-1:PW-2];
      end
    end

    // Rotation by the conjugate oscillator phase
    always_comb begin
      if (cplx1) begin
        sumI = mul(xI, oscCos) + mul(xQ, oscSin);
        sumQ = mul(xQ, oscCos) - mul(xI, oscSin);
      end else begin
        sumI = mul(xI, oscCos);
        sumQ = -mul(xI, oscSin);
      end
    end

    always_comb begin
      unique case (mode1)
        IF_ZERO: begin
          outI = xI;
          outQ = xQ;
        end
        IF_QUARTER: begin
          unique case (quad1)
            2'b00: begin
              outI = xI;
              outQ = xQ;
            end
            2'b01: begin
              outI = xQ;
              outQ = negSat(xI);
            end
            2'b10: begin
              outI = negSat(xI);
              outQ = negSat(xQ);
            end
            2'b11: begin
              outI = negSat(xQ);
              outQ = xI;
            end
          endcase
        end
        IF_VARIABLE, IF_TEST: begin
          if (cplx1) begin
            outI = roundSat(mul(roundSat(sumI, SHIFT_REAL),
                                COMPLEX_SCALE), SHIFT_REAL);
            outQ = roundSat(mul(roundSat(sumQ, SHIFT_REAL),
                                COMPLEX_SCALE), SHIFT_REAL);
          end else begin
            outI = roundSat(sumI, SHIFT_REAL);
            outQ = roundSat(sumQ, SHIFT_REAL);
          end
        end
      endcase
    end

    // Stage two: registered baseband output
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        mixOut[c] <= '0;
      end else begin
        mixOut[c].valid <= v1;
        mixOut[c].i <= outI;
        mixOut[c].q <= outQ;
      end
    end
  end
endmodule : ddc_nco_mixer_translation

// ===== sample_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Converter sample source
// ----------------------------------------
module sample_src
  import ddc_pkg::*;
(
  input logic sys_clk,
  output ddc_pkg::stream_t adcOut
);
  initial adcOut = '0;
  // One sample per call; data inverted while idle
  task automatic send(input smp_t i, input smp_t q);
    @(posedge sys_clk);
    adcOut <= '{1'b1, i, q};
    @(posedge sys_clk);
    adcOut <= '{1'b0, ~i, ~q};
  endtask : send
endmodule : sample_src

// ===== ddc_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module ddc_props
  import ddc_pkg::*;
(
  input logic sys_clk,
  input logic srst,
  input ddc_pkg::apb_req_t apbReq,
  input ddc_pkg::apb_rsp_t apbRsp,
  input logic sysrefPin,
  input ddc_pkg::stream_t adcIn,
  input ddc_pkg::stream_t [ddc_pkg::NCH-1:0] mixOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rdy_next;
    apbReq.psel && !apbReq.penable |=> apbRsp.pready;
  endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("pready late");
  property p_rdy_one;
    apbRsp.pready |=> !apbRsp.pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready held");
  property p_err_zero;
    apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error");
  property p_unal;
    apbReq.psel && !apbReq.penable && apbReq.paddr[1:0] != 2'b00
      |=> apbRsp.pslverr;
  endproperty
  a_unal: assert property (p_unal) else $error("no error");
  property p_cause;
    $rose(apbRsp.pready) |-> $past(apbReq.psel && !apbReq.penable);
  endproperty
  a_cause: assert property (p_cause) else $error("stray pready");
  property p_lat;
    adcIn.valid |-> ##2 mixOut[0].valid;
  endproperty
  a_lat: assert property (p_lat) else $error("output late");
  property p_idle;
    !adcIn.valid |-> ##2 !mixOut[2].valid;
  endproperty
  a_idle: assert property (p_idle) else $error("output spurious");
  property p_src;
    mixOut[3].valid |-> $past(adcIn.valid, 2);
  endproperty
  a_src: assert property (p_src) else $error("no source");
  property p_lanes;
    mixOut[0].valid == mixOut[1].valid && mixOut[2].valid == mixOut[3].valid;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lanes split");
endmodule : ddc_props

bind ddc_nco_mixer_translation ddc_props u_props (.sys_clk(sys_clk),
  .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .sysrefPin(sysrefPin),
  .adcIn(adcIn), .mixOut(mixOut));

// ===== ddc_nco_mixer_translation_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module ddc_nco_mixer_translation_tb;
  import ddc_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic sysrefPin = 1'b0;
  apb_req_t apbReq = '0;
  apb_rsp_t apbRsp;
  stream_t adcIn;
  stream_t [NCH-1:0] mixOut;
  int nFail = 0;
  int cmpCount = 0;
  int cycles = 0;
  logic [31:0] rdat;
  logic rerr;
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
  initial forever #50 sys_clk = ~sys_clk;
  ddc_nco_mixer_translation dut (.sys_clk(sys_clk), .srst(srst),
    .apbReq(apbReq), .apbRsp(apbRsp), .sysrefPin(sysrefPin),
    .adcIn(adcIn), .mixOut(mixOut));
  sample_src src (.sys_clk(sys_clk), .adcOut(adcIn));
  function automatic logic [IW-1:0] cr(int c, logic [1:0] s);
    return IW'(IDX_CH_CTRL0 + CH_STRIDE * c + s);
  endfunction : cr
  function automatic logic [31:0] stepWord(int fc, int fs);
    int m;
    m = fc % fs;
    m = m * (1 << PW);
    m = (m < 0) ? (m - fs / 2) / fs : (m + fs / 2) / fs;
    return {20'h0_0000, m[PW-1:0]};
  endfunction : stepWord
  function automatic smp_t rnd(int x, int c);
    int p;
    p = (x * c + 32'sh0000_4000) >>> 15;
    if (p > SMP_MAX) p = SMP_MAX;
    if (p < SMP_MIN) p = SMP_MIN;
    return smp_t'(p);
  endfunction : rnd
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apbRsp.pready !== 1'b1);
    rdat = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [IW-1:0] ix, input logic [31:0] d);
    xfer(1'b1, {ix, 2'b00}, d);
  endtask : wr
  task automatic rd(input string nm, input logic [IW-1:0] ix,
                    input logic [31:0] e);
    xfer(1'b0, {ix, 2'b00}, 32'h0000_0000);
    `CHK(nm, e, rdat)
  endtask : rd
  task automatic smp(input smp_t i, input smp_t q);
    src.send(i, q);
    @(posedge sys_clk);
    #1;
  endtask : smp
  task automatic ck(input int c, input smp_t ei, input smp_t eq);
    `CHK("valid", 1'b1, mixOut[c].valid)
    `CHK("mix i", ei, mixOut[c].i)
    `CHK("mix q", eq, mixOut[c].q)
  endtask : ck
  task automatic endOfTest();
    $display("compares %0d errors %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : endOfTest
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nFail++;
      endOfTest();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rd("ctrl rst", cr(0, SUB_CTRL), 32'h0000_0000);
    rd("step rst", cr(1, SUB_STEP), 32'h0000_0000);
    rd("unmapped", 10'h3FF, 32'h0000_0000);
    `CHK("slverr", 1'b1, rerr)
    xfer(1'b0, 12'hC42, 32'h0000_0000);
    `CHK("unaligned", 1'b1, rerr)
    wr(cr(0, SUB_STEP), stepWord(-1, 2));
    wr(cr(3, SUB_STEP), stepWord(1, 16));
    wr(cr(0, SUB_START), 32'h0000_0010);
    wr(cr(1, SUB_START), 32'h0000_0400);
    wr(cr(3, SUB_START), 32'h0000_0020);
    rd("step", cr(0, SUB_STEP), 32'h0000_0800);
    wr(IDX_SYNC_CTRL, 32'h0000_0010);
    rd("phase", cr(0, SUB_PHASE), 32'h0000_0010);
    rd("soft", IDX_SYNC_STAT, 32'h0000_0100);
    wr(cr(0, SUB_CTRL), 32'h0000_0010);
    wr(cr(1, SUB_CTRL), 32'h0000_00A0);
    wr(cr(3, SUB_CTRL), 32'h0000_0030);
    rd("ctrl", cr(1, SUB_CTRL), 32'h0000_00A0);
    smp(14'sh2000, 14'sh0064);
    ck(0, 14'sh2000, 14'sh0000);
    ck(1, 14'sh0064, 14'sh1FFF);
    ck(2, rnd(14'sh2000, 16'h7F43), 14'sh0000);
    ck(3, rnd(14'sh1FF7, 16'h7F43), 14'sh0000);
    wr(cr(1, SUB_CTRL), 32'h0000_0080);
    smp(14'sh2000, 14'sh0064);
    ck(1, rnd(rnd(14'sh0064, 16'h7F43), 16'h59FF),
       rnd(rnd(32'sh0000_2000, 16'h7F43), 16'h59FF));
    wr(IDX_SYNC_CTRL, 32'h0000_0000);
    repeat (3) smp(14'sh0000, 14'sh0000);
    wr(cr(0, SUB_PHASE), 32'h0000_0FFF);
    rd("zif hold", cr(0, SUB_PHASE), 32'h0000_0010);
    rd("acc run", cr(3, SUB_PHASE), 32'h0000_0320);
    wr(IDX_SYSREF_CTRL2, 32'h0000_005A);
    rd("sysref2", IDX_SYSREF_CTRL2, 32'h0000_005A);
    wr(IDX_SYSREF_CTRL, 32'h0000_0001);
    wr(IDX_SYNC_CTRL, 32'h0000_0001);
    @(posedge sys_clk);
    sysrefPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sysrefPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd("acc sysref", cr(3, SUB_PHASE), 32'h0000_0020);
    rd("sync count", IDX_SYNC_STAT, 32'h0000_0001);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd("ctrl rst2", cr(1, SUB_CTRL), 32'h0000_0000);
    rd("acc rst2", cr(3, SUB_PHASE), 32'h0000_0000);
    endOfTest();
  end
endmodule : ddc_nco_mixer_translation_tb
